// [hdl/param_bank_pkg.sv]
/*
 Package for the drive parameter management bank: parameter addresses,
 command codes, widths and timing counts.
 Assumes nothing of its surroundings.
*/
package param_bank_pkg;

   // Parameter addresses on the fieldbus (byte-free parameter numbers)
   localparam logic [15:0] ADDR_NV_SAVE = 16'h0402;
   localparam logic [15:0] ADDR_CTRL_RESET = 16'h040e;
   localparam logic [15:0] ADDR_USER_RESET = 16'h0410;
   localparam logic [15:0] ADDR_DC_MAX = 16'h1006;
   localparam logic [15:0] ADDR_DC_MIN = 16'h1008;
   localparam logic [15:0] ADDR_TEMP_WARN = 16'h100c;
   localparam logic [15:0] ADDR_DC_QSTOP = 16'h1014;

   // Command values and field positions
   localparam logic [15:0] CMD_YES = 16'h0001;
   localparam logic [15:0] CMD_NONE = 16'h0000;
   localparam logic [15:0] FACTORY_MAX = 16'h0003;
   localparam int USER_RESET_BIT = 0;

   // Read-only limit defaults (plain values, overridable at the top)
   localparam logic [15:0] DEF_TEMP_WARN = 16'h0050;
   localparam logic [15:0] DEF_DC_MAX = 16'h0190;
   localparam logic [15:0] DEF_DC_MIN = 16'h0064;
   localparam logic [15:0] DEF_DC_QSTOP = 16'h0078;

   // Busy time of a nonvolatile store, cycles
   localparam int NV_BUSY_CYCLES = 64;

   // Read response group
   typedef struct packed {
      logic valid;
      logic error;
      logic [15:0] data;
   } rd_resp_t;

   // Pulses to the rest of the drive
   typedef struct packed {
      logic ctrl_reset;
      logic user_reset;
      logic factory_load;
      logic nv_store;
   } action_t;

endpackage : param_bank_pkg

// [hdl/drive_param_management_bank.sv]
/*
 Parameter management bank of a motor drive: read-only supervision limits,
 command parameters (save, control loop reset, user reset, factory restore)
 and the DC bus quick-stop compare.
 Assumes one clock, a synchronous reset, a single-cycle parameter access
 port from the fieldbus side, and an nonvolatile store busy/done handshake
 modelled here by a fixed busy count. Power stage enable comes from a pin.
 The DC bus word is filtered for torn samples, adding two cycles to quick stop.
*/
// Behaviour
// RQ1: Read-only signed 16-bit power stage temperature limit for lowest error class.
// RQ2: Read-only unsigned 16-bit maximum DC bus voltage in tenth-volt counts.
// RQ3: Read-only unsigned 16-bit minimum DC bus voltage in tenth-volt counts.
// RQ4: DC bus at or below quick-stop level triggers a quick stop.
// RQ5: Writing 1 to control loop reset resets velocity and position loops; 0 does nothing.
// RQ6: Control loop reset also retunes the current controller to the motor.
// RQ7: Writing 1 to save starts copying persistent parameters to nonvolatile memory.
// RQ8: Save parameter reads 0 once saving is done; master polls for 0.
// RQ9: Factory restore (0..3) loads defaults, stores them, reads 0 when done.
// RQ10: Master issues factory restore only via commissioning path, no fieldbus address.
// RQ11: Factory restore only with power stage off; takes effect at next power-on.
// RQ12: User reset bit 0 restores user defaults except comms, direction, interface, I/O.
// RQ13: User reset bits 1 and 2 are reserved and have no function.
// RQ14: User reset does not write to nonvolatile memory.
// RQ15: User reset only with power stage off; active at next power stage enable.
// RQ16: Guarded command written while power stage is on is rejected, nothing changes.
`timescale 1ns/1ps

module drive_param_management_bank
   import param_bank_pkg::*;
#(
   parameter logic [15:0] TEMP_WARN = DEF_TEMP_WARN,
   parameter logic [15:0] DC_MAX = DEF_DC_MAX,
   parameter logic [15:0] DC_MIN = DEF_DC_MIN,
   parameter logic [15:0] DC_QSTOP = DEF_DC_QSTOP
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Fieldbus parameter access
   input wire logic req_i,
   input wire logic wr_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   output rd_resp_t resp_o,
   // Commissioning tool path
   input wire logic factory_wr_i,
   input wire logic [15:0] factory_data_i,
   output logic [15:0] factory_rdata_o,
   // Drive status pins
   input wire logic stage_enabled_i,
   input wire logic [15:0] dc_bus_i,
   // Actions to the drive
   output action_t action_o,
   output logic quick_stop_o,
   output logic user_pending_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers: stage enable and bus measurement are asynchronous
   logic stage_m;
   logic stage_s;
   logic [15:0] dc_m;
   logic [15:0] dc_s;
   logic [15:0] dc_q;
   // The bus word is synchronised bit by bit, so a changing value can arrive
   // torn; it is only used once two samples in a row agree
   always_ff @(posedge clk_i) begin
      stage_m <= stage_enabled_i;
      stage_s <= stage_m;
      dc_m <= dc_bus_i;
      dc_s <= dc_m;
      dc_q <= dc_s;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
      hit = (a == reg_addr);
   endfunction : hit

   // Sequencer state; busy_cnt holds the cycles left in the current store
   typedef enum {NV_IDLE, NV_SAVE, NV_FACTORY} nv_state_t;

   nv_state_t state;
   nv_state_t next_state;
   logic [7:0] busy_cnt;
   logic [7:0] next_busy_cnt;
   logic [15:0] save_reg;
   logic [15:0] next_save_reg;
   logic [15:0] factory_reg;
   logic [15:0] next_factory_reg;
   logic user_pending;
   logic next_user_pending;
   logic stage_prev;
   rd_resp_t next_resp;
   action_t next_action;
   logic next_qstop;
   logic [15:0] dc_word;
   logic [15:0] next_dc_word;

   // Write strobes, one per command parameter; the tool path has its own
   logic wr_save;
   logic wr_ctrl;
   logic wr_user;
   logic fac_ok;
   assign wr_save = req_i && wr_i && hit(addr_i, ADDR_NV_SAVE);
   assign wr_ctrl = req_i && wr_i && hit(addr_i, ADDR_CTRL_RESET);
   assign wr_user = req_i && wr_i && hit(addr_i, ADDR_USER_RESET);
   // Factory restore exists only on the tool path, not on the fieldbus map
   assign fac_ok = factory_wr_i && !stage_s && factory_data_i <= FACTORY_MAX; // RQ11 RQ16

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic for commands, store sequencer and read data
   always_comb begin
      next_state = state;
      next_busy_cnt = busy_cnt;
      next_save_reg = save_reg;
      next_factory_reg = factory_reg;
      next_user_pending = user_pending;
      next_action = '0;
      next_resp = '0;
      // Torn words never reach the compare; costs two extra cycles of latency
      next_dc_word = (dc_s == dc_q) ? dc_s : dc_word;
      next_qstop = (dc_word <= DC_QSTOP); // RQ4
      // Store sequencer; a new save or restore command that arrives while a store is busy is dropped
      case (state)
         NV_IDLE: begin
            if (fac_ok && factory_data_i != CMD_NONE) begin
               next_action.factory_load = 1'b1; // RQ9
               next_factory_reg = factory_data_i;
               next_busy_cnt = 8'(NV_BUSY_CYCLES);
               next_state = NV_FACTORY;
            end else if (wr_save && wdata_i == CMD_YES) begin
               next_save_reg = CMD_YES; // RQ7
               next_busy_cnt = 8'(NV_BUSY_CYCLES);
               next_state = NV_SAVE;
            end
         end
         NV_SAVE, NV_FACTORY: begin
            // The store is told once, on the first busy cycle
            next_action.nv_store = (busy_cnt == 8'(NV_BUSY_CYCLES)); // RQ7 RQ9
            if (busy_cnt == 8'h01) begin
               next_save_reg = CMD_NONE; // RQ8
               next_factory_reg = CMD_NONE; // RQ9
               next_state = NV_IDLE;
            end
            next_busy_cnt = busy_cnt - 8'h01;
         end
         default: begin
            next_state = NV_IDLE;
         end
      endcase
      // Loop reset retunes current loop too, handled by the ctrl_reset pulse
      if (wr_ctrl && wdata_i == CMD_YES) begin
         next_action.ctrl_reset = 1'b1; // RQ5 RQ6
      end
      // Only bit 0 acts; reserved bits ignored; no store is started
      if (wr_user && wdata_i[USER_RESET_BIT] && !stage_s) begin
         next_user_pending = 1'b1; // RQ12 RQ13 RQ14 RQ15 RQ16
      end
      // Pending user defaults apply on the next power stage enable
      if (user_pending && stage_s && !stage_prev) begin
         next_action.user_reset = 1'b1; // RQ15
         next_user_pending = 1'b0;
      end
      // Read answers; unmapped addresses answer with error and zero
      if (req_i && !wr_i) begin
         next_resp.valid = 1'b1;
         case (addr_i)
            ADDR_TEMP_WARN: next_resp.data = TEMP_WARN; // RQ1
            ADDR_DC_MAX: next_resp.data = DC_MAX; // RQ2
            ADDR_DC_MIN: next_resp.data = DC_MIN; // RQ3
            ADDR_DC_QSTOP: next_resp.data = DC_QSTOP; // RQ4
            ADDR_NV_SAVE: next_resp.data = save_reg; // RQ8
            ADDR_CTRL_RESET: next_resp.data = CMD_NONE;
            // User reset reads back as pending until the stage comes on
            ADDR_USER_RESET: next_resp.data = {15'h0000, user_pending};
            default: next_resp.error = 1'b1;
         endcase
      end else if (req_i && wr_i) begin
         next_resp.valid = 1'b1;
         // Writes to read-only, unmapped or guarded-while-enabled are refused
         next_resp.error = !(wr_save || wr_ctrl || (wr_user && !stage_s)); // RQ16
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers
   // Outputs come straight from these registers, so the bus side sees no glitch
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= NV_IDLE;
         busy_cnt <= 8'h00;
         save_reg <= CMD_NONE;
         factory_reg <= CMD_NONE;
         user_pending <= 1'b0;
         stage_prev <= 1'b0;
         dc_word <= DC_MAX;
         resp_o <= '0;
         action_o <= '0;
         quick_stop_o <= 1'b0;
         factory_rdata_o <= CMD_NONE;
         user_pending_o <= 1'b0;
      end else begin
         state <= next_state;
         busy_cnt <= next_busy_cnt;
         save_reg <= next_save_reg;
         factory_reg <= next_factory_reg;
         user_pending <= next_user_pending;
         stage_prev <= stage_s;
         dc_word <= next_dc_word;
         resp_o <= next_resp;
         action_o <= next_action;
         quick_stop_o <= next_qstop;
         factory_rdata_o <= next_factory_reg;
         user_pending_o <= next_user_pending;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // Limit reads answer the top parameters one cycle after the request
   AST_TEMP_READ: assert property (req_i && !wr_i && addr_i == ADDR_TEMP_WARN |=> // RQ1
      resp_o.valid && resp_o.data == TEMP_WARN) else $error("temperature limit read wrong");
   AST_DCMAX_READ: assert property (req_i && !wr_i && addr_i == ADDR_DC_MAX |=> // RQ2
      resp_o.data == DC_MAX) else $error("dc max read wrong");
   AST_DCMIN_READ: assert property (req_i && !wr_i && addr_i == ADDR_DC_MIN |=> // RQ3
      resp_o.data == DC_MIN) else $error("dc min read wrong");
   // Quick stop follows the pin once the filtered word has settled, five edges on
   AST_QSTOP_SET: assert property ((dc_bus_i <= DC_QSTOP) [*5] |=> quick_stop_o) // RQ4
      else $error("quick stop missed");
   AST_QSTOP_CLR: assert property ((dc_bus_i > DC_QSTOP) [*5] |=> !quick_stop_o) // RQ4
      else $error("quick stop without low bus");
   // Command effects
   AST_CTRL_PULSE: assert property (wr_ctrl && wdata_i == CMD_YES |=> // RQ5
      action_o.ctrl_reset) else $error("loop reset not issued");
   AST_CTRL_NOACT: assert property (wr_ctrl && wdata_i == CMD_NONE |=> // RQ5
      !action_o.ctrl_reset) else $error("loop reset on zero");
   AST_SAVE_START: assert property (state == NV_IDLE && !fac_ok && wr_save && // RQ7
      wdata_i == CMD_YES |=> save_reg == CMD_YES ##1 action_o.nv_store)
      else $error("save did not start");
   AST_SAVE_DONE: assert property (state == NV_SAVE |-> ##[1:70] save_reg == CMD_NONE) // RQ8
      else $error("save never completed");
   AST_FACT_DONE: assert property (state == NV_FACTORY |-> ##[1:70] // RQ9
      factory_reg == CMD_NONE) else $error("factory restore never completed");
   // Power stage guards
   AST_FACT_GUARD: assert property (factory_wr_i && stage_s && state == NV_IDLE && // RQ11
      !wr_save |=> state == NV_IDLE) else $error("factory restore with stage enabled");
   AST_USER_GUARD: assert property (wr_user && stage_s && !user_pending |=> // RQ16
      !user_pending) else $error("user reset accepted while enabled");
   AST_USER_NOSTORE: assert property (wr_user && state == NV_IDLE && !wr_save && // RQ14
      !fac_ok |=> state == NV_IDLE) else $error("user reset started a store");
   AST_USER_RSVD: assert property (wr_user && !wdata_i[0] && !user_pending |=> // RQ13
      !user_pending) else $error("reserved bit acted");
   AST_USER_APPLY: assert property (user_pending && stage_s && !stage_prev |=> // RQ12 RQ15
      action_o.user_reset) else $error("user defaults not applied");

   // Readbacks and refusals on the parameter port
   AST_QSTOP_READ: assert property (req_i && !wr_i && addr_i == ADDR_DC_QSTOP |=> // RQ4
      resp_o.data == DC_QSTOP) else $error("quick stop level read wrong");
   AST_RO_WRITE: assert property (req_i && wr_i && (addr_i == ADDR_TEMP_WARN || // RQ1 RQ2 RQ3 RQ4
      addr_i == ADDR_DC_MAX || addr_i == ADDR_DC_MIN || addr_i == ADDR_DC_QSTOP) |=>
      resp_o.valid && resp_o.error) else $error("limit write not refused");
   AST_CTRL_READ: assert property (req_i && !wr_i && addr_i == ADDR_CTRL_RESET |=> // RQ5
      resp_o.data == CMD_NONE) else $error("loop reset reads nonzero");
   AST_SAVE_BUSY_READ: assert property (req_i && !wr_i && addr_i == ADDR_NV_SAVE && // RQ8
      state == NV_SAVE |=> resp_o.data == CMD_YES) else $error("save not shown busy");
   AST_SAVE_IDLE_READ: assert property (req_i && !wr_i && addr_i == ADDR_NV_SAVE && // RQ8
      state == NV_IDLE |=> resp_o.data == CMD_NONE) else $error("idle save reads nonzero");
   AST_READ_VALID: assert property (req_i && !wr_i |=> resp_o.valid) // RQ8
      else $error("read not answered");

   // Store sequencer: one store per command, restores refused while busy
   AST_STORE_PULSE: assert property (action_o.nv_store |=> !action_o.nv_store) // RQ7
      else $error("store pulse too long");
   AST_CMD_ACK: assert property ((wr_save || wr_ctrl) |=> resp_o.valid && !resp_o.error) // RQ5 RQ7
      else $error("command write refused");
   AST_FACT_START: assert property (state == NV_IDLE && fac_ok && // RQ9
      factory_data_i != CMD_NONE |=> action_o.factory_load ##1 action_o.nv_store)
      else $error("factory restore did not start");
   AST_FACT_RANGE: assert property (factory_wr_i && factory_data_i > FACTORY_MAX && // RQ9
      state == NV_IDLE && !wr_save |=> state == NV_IDLE) else $error("restore above range");
   AST_FACT_BUSY: assert property (factory_wr_i && state != NV_IDLE |=> // RQ9
      !action_o.factory_load) else $error("restore taken while busy");
   AST_FACT_RDATA: assert property (state == NV_FACTORY |-> factory_rdata_o != CMD_NONE) // RQ9
      else $error("factory command reads zero while busy");

   // User reset answers: accepted while off, refused while on
   AST_USER_SET: assert property (wr_user && wdata_i[USER_RESET_BIT] && !stage_s |=> // RQ12
      user_pending_o) else $error("user reset not held pending");
   AST_USER_ACK: assert property (wr_user && !stage_s |=> resp_o.valid && !resp_o.error) // RQ15
      else $error("user reset refused while off");
   AST_USER_ERR: assert property (wr_user && stage_s |=> resp_o.valid && resp_o.error) // RQ16
      else $error("user reset not refused while on");

   // Main scenarios
   COV_SAVE: cover property (state == NV_SAVE ##1 state == NV_IDLE);
   COV_FACT: cover property (state == NV_FACTORY);
   COV_USER: cover property (action_o.user_reset);
   COV_QSTOP: cover property (quick_stop_o);
   COV_REFUSE: cover property (resp_o.valid && resp_o.error);

endmodule : drive_param_management_bank

// [test/fieldbus_master.sv]
/*
 Fieldbus master model: single-cycle parameter accesses, polling, and the
 commissioning restore strobe. Assumes answers one cycle after the request.
*/
`timescale 1ns/1ps
module fieldbus_master
   import param_bank_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Parameter access
   output logic req_o,
   output logic wr_o,
   output logic [15:0] addr_o,
   output logic [15:0] wdata_o,
   input wire rd_resp_t resp_i,
   // Commissioning path
   output logic fwr_o,
   output logic [15:0] fdata_o
);
   initial begin
      req_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 16'h0;
      wdata_o = 16'h0;
      fwr_o = 1'b0;
      fdata_o = 16'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One access; released address and data lines show inverted values so stale data never passes
   task access(input logic w, input logic [15:0] a, input logic [15:0] d,
      output rd_resp_t r);
      @(posedge clk_i);
      req_o <= 1'b1;
      wr_o <= w;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      req_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
      #1 r = resp_i;
   endtask : access
   // Completion is only known by reading zero back, so poll with a bound
   task poll(input logic [15:0] a, output rd_resp_t r);
      int k;
      k = 0;
      access(1'b0, a, 16'h0, r);
      while (r.data !== 16'h0 && k < 100) begin
         access(1'b0, a, 16'h0, r);
         k++;
      end
   endtask : poll
   // Restore has no fieldbus address, only the commissioning strobe
   task restore(input logic [15:0] v);
      @(posedge clk_i);
      fwr_o <= 1'b1;
      fdata_o <= v;
      @(posedge clk_i);
      fwr_o <= 1'b0;
      fdata_o <= ~v;
   endtask : restore
endmodule : fieldbus_master

// [test/test_drive_param_management_bank.sv]
/*
 Bench for the parameter bank: limit reads, refused accesses, commands
 and status pins. Assumes the package defaults for the limit values.
*/
`timescale 1ns/1ps
module test_drive_param_management_bank;
   import param_bank_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic stg = 1'b0;
   logic [15:0] dc = 16'h0200;
   logic req, wr, fwr, qs, pend;
   logic [15:0] addr, wdata, fdata, frd;
   rd_resp_t resp, r;
   action_t act;
   int error_cnt = 0;
   int check_count = 0;
   int cnt[4] = '{0, 0, 0, 0};
   logic [15:0] ro_a[4] = '{ADDR_TEMP_WARN, ADDR_DC_MAX, ADDR_DC_MIN, ADDR_DC_QSTOP};
   logic [15:0] ro_v[4] = '{DEF_TEMP_WARN, DEF_DC_MAX, DEF_DC_MIN, DEF_DC_QSTOP};
   ////////////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;
   fieldbus_master fm (.clk_i(clk_i), .req_o(req), .wr_o(wr), .addr_o(addr),
      .wdata_o(wdata), .resp_i(resp), .fwr_o(fwr), .fdata_o(fdata));
   drive_param_management_bank dut (.clk_i(clk_i), .reset_i(reset_i), .req_i(req),
      .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .resp_o(resp), .factory_wr_i(fwr),
      .factory_data_i(fdata), .factory_rdata_o(frd), .stage_enabled_i(stg),
      .dc_bus_i(dc), .action_o(act), .quick_stop_o(qs), .user_pending_o(pend));
   // Pulse tally: 3 control reset, 2 user reset, 1 factory load, 0 store
   always @(posedge clk_i) for (int i = 0; i < 4; i++) cnt[i] += act[i];
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task test_done;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      test_done();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      // Limits read back and refuse writes
      for (int i = 0; i < 4; i++) begin
         fm.access(1'b1, ro_a[i], 16'h1234, r);
         chk("ro wr error", {15'h0, r.error}, 16'h1);
         fm.access(1'b0, ro_a[i], 16'h0, r);
         chk("ro valid", {15'h0, r.valid}, 16'h1);
         chk("ro data", r.data, ro_v[i]);
      end
      fm.access(1'b0, 16'h0400, 16'h0, r);
      chk("unmapped", {r.error, r.data[14:0]}, 16'h8000);
      $display("test limits done");
      // Quick stop at the threshold, not above it; the filtered word needs five edges
      @(posedge clk_i);
      dc <= DEF_DC_QSTOP + 16'h1;
      repeat (8) @(posedge clk_i);
      chk("qs above", {15'h0, qs}, 16'h0);
      dc <= DEF_DC_QSTOP;
      repeat (8) @(posedge clk_i);
      chk("qs at", {15'h0, qs}, 16'h1);
      dc <= 16'h0200;
      repeat (8) @(posedge clk_i);
      chk("qs clear", {15'h0, qs}, 16'h0);
      $display("test quick stop done");
      // Control loop reset: 0 idle, 1 one pulse
      fm.access(1'b1, ADDR_CTRL_RESET, CMD_NONE, r);
      fm.access(1'b1, ADDR_CTRL_RESET, CMD_YES, r);
      repeat (3) @(posedge clk_i);
      chk("ctrl pulses", 16'(cnt[3]), 16'h1);
      fm.access(1'b0, ADDR_CTRL_RESET, 16'h0, r);
      chk("ctrl rd", r.data, CMD_NONE);
      $display("test control reset done");
      // Save twice back to back: the second lands while busy
      fm.access(1'b1, ADDR_NV_SAVE, CMD_YES, r);
      fm.access(1'b1, ADDR_NV_SAVE, CMD_YES, r);
      fm.access(1'b0, ADDR_NV_SAVE, 16'h0, r);
      chk("save busy", r.data, 16'h1);
      fm.poll(ADDR_NV_SAVE, r);
      chk("save done", r.data, 16'h0);
      chk("store pulses", 16'(cnt[0]), 16'h1);
      $display("test save done");
      // User reset: reserved bits, pending, no store, guard
      fm.access(1'b1, ADDR_USER_RESET, 16'h0006, r);
      chk("reserved", {15'h0, pend}, 16'h0);
      fm.access(1'b1, ADDR_USER_RESET, 16'h0001, r);
      chk("pending", {15'h0, pend}, 16'h1);
      fm.access(1'b0, ADDR_USER_RESET, 16'h0, r);
      chk("user rd", r.data, 16'h0001);
      @(posedge clk_i);
      stg <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk("user pulse", 16'(cnt[2]), 16'h1);
      chk("no store", 16'(cnt[0]), 16'h1);
      fm.access(1'b1, ADDR_USER_RESET, 16'h0001, r);
      chk("guard err", {r.error, 14'h0, pend}, 16'h8000);
      $display("test user reset done");
      // Factory restore: guarded, range checked, then load and store
      fm.restore(16'h0001);
      stg <= 1'b0;
      repeat (5) @(posedge clk_i);
      fm.restore(16'h0004);
      repeat (3) @(posedge clk_i);
      chk("fac refused", 16'(cnt[1]), 16'h0);
      fm.restore(FACTORY_MAX);
      repeat (2) @(posedge clk_i);
      chk("fac busy", frd, FACTORY_MAX);
      repeat (200) @(posedge clk_i);
      chk("fac rd", frd, 16'h0);
      chk("fac load", 16'(cnt[1]), 16'h1);
      chk("fac store", 16'(cnt[0]), 16'h2);
      $display("test factory done");
      test_done();
   end
endmodule : test_drive_param_management_bank
